// ### src/sci_pkg.sv
// constants, field layouts and carrier types of the serial interface
// assumes a single clk domain; the receive pin is resynchronised inside the block
package sci_pkg;
   // register byte offsets on the avalon-mm slave
   localparam logic [4:0] OFS_STATUS = 5'h00;
   localparam logic [4:0] OFS_DATA = 5'h04;
   localparam logic [4:0] OFS_CTRL1 = 5'h08;
   localparam logic [4:0] OFS_CTRL2 = 5'h0C;
   localparam logic [4:0] OFS_BAUD = 5'h10;
   // status_port_reg bit positions
   localparam int ST_TXE = 7;
   localparam int ST_TC = 6;
   localparam int ST_RXF = 5;
   localparam int ST_IDLE = 4;
   localparam int ST_OVR = 3;
   localparam int ST_NOISE = 2;
   localparam int ST_FE = 1;
   // control_reg_one bit positions
   localparam int C1_RX9 = 7;
   localparam int C1_TX9 = 6;
   localparam int C1_WORD9 = 4;
   // prescaler values selected by baud_prescale_field
   localparam logic [10:0] PRE_SEL0 = 11'h001;
   localparam logic [10:0] PRE_SEL1 = 11'h003;
   localparam logic [10:0] PRE_SEL2 = 11'h004;
   localparam logic [10:0] PRE_SEL3 = 11'h00D;
   // frame lengths in bits (start + data + stop)
   localparam logic [3:0] FRAME_BITS_8 = 4'hA;
   localparam logic [3:0] FRAME_BITS_9 = 4'hB;
   localparam logic [3:0] DATA_BITS_8 = 4'h8;
   localparam logic [3:0] DATA_BITS_9 = 4'h9;
   // oversampling: 16 ticks a bit, index 16 wraps to zero
   localparam logic [3:0] TICK_LAST = 4'hF;
   localparam logic [3:0] SMP_3 = 4'h3;
   localparam logic [3:0] SMP_5 = 4'h5;
   localparam logic [3:0] SMP_7 = 4'h7;
   localparam logic [3:0] SMP_8 = 4'h8;
   localparam logic [3:0] SMP_10 = 4'hA;
   // ticks of an all-ones frame on the receive line
   localparam logic [7:0] IDLE_TICKS_8 = 8'hA0;
   localparam logic [7:0] IDLE_TICKS_9 = 8'hB0;
   // software controls carried as one word
   typedef struct packed {
      logic word9;      // 9-bit words
      logic tx9;        // tx_ninth_bit
      logic ien_txe;    // tx_empty_irq_en
      logic ien_tc;     // tx_done_irq_en
      logic ien_rx;     // rx_full_irq_en
      logic ien_idle;   // idle_irq_en
      logic te;         // tx_enable
      logic re;         // rx_enable
      logic brk;        // send_break_ctrl
   } ctrl_t;
   // baud_select_reg layout
   typedef struct packed {
      logic [1:0] pre;  // baud_prescale_field
      logic [2:0] tdiv; // tx_divider_field
      logic [2:0] rdiv; // rx_divider_field
   } baud_t;
   typedef enum logic [2:0] {TX_OFF, TX_READY, TX_PREAMBLE, TX_DATA, TX_BREAK, TX_MARK} tx_state_t;
   typedef enum logic [1:0] {RX_OFF, RX_HUNT, RX_FRAME} rx_state_t;
endpackage

// ### src/sci_baud_tick.sv
// oversampling tick generator: one pulse every prescaler * 2**divider clocks
// assumes the selection stays still while run is high
module sci_baud_tick #(
   parameter int CW = 11
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic en,
   input wire logic run,
   input wire logic [1:0] pre_sel,
   input wire logic [2:0] div_sel,
   output logic tick
);
   typedef struct packed {
      logic [CW-1:0] cnt; // clocks since last tick
      logic tick;         // one-cycle pulse
   } bt_t;
   bt_t q;
   bt_t n;
   logic [CW-1:0] pre;
   logic [CW-1:0] limit;

   ////////////////////////////////////////////////////////////////////////////
   // divider ratio; 13 * 128 is the largest and still fits CW bits
   always_comb begin
      unique case (pre_sel)
         2'h0: pre = CW'(sci_pkg::PRE_SEL0);
         2'h1: pre = CW'(sci_pkg::PRE_SEL1);
         2'h2: pre = CW'(sci_pkg::PRE_SEL2);
         2'h3: pre = CW'(sci_pkg::PRE_SEL3);
      endcase
      limit = CW'((pre << div_sel) - CW'(1));
      n = q;
      n.tick = 1'b0;
      // stopped divider restarts from zero so the first tick is a full period
      if (!run) begin
         n.cnt = '0;
      end else if (q.cnt >= limit) begin
         n.cnt = '0;
         n.tick = 1'b1;
      end else begin
         n.cnt = CW'(q.cnt + CW'(1));
      end
   end

   // state register, frozen while en is low
   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= '0;
      end else if (en) begin
         q <= n;
      end
   end
   assign tick = q.tick;
endmodule

// ### src/sci_pin_sync.sv
// two-flop synchroniser for the asynchronous receive pin
// assumes the pin idles high; reset loads ones so no false start is seen
module sci_pin_sync (
   input wire logic clk,
   input wire logic nrst,
   input wire logic en,
   input wire logic pin,
   output logic q_sync
);
   typedef struct packed {
      logic s1; // metastable stage, read only by s2
      logic s2; // safe stage
   } ps_t;
   ps_t q;
   ps_t n;

   ////////////////////////////////////////////////////////////////////////////
   // shift the pin through both stages
   always_comb begin
      n = q;
      n.s1 = pin;
      n.s2 = q.s1;
   end

   // state register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= '1;
      end else if (en) begin
         q <= n;
      end
   end
   assign q_sync = q.s2;
endmodule

// ### src/sci_top.sv
// full-duplex asynchronous serial interface with avalon-mm register slave
// assumes clk at 40 MHz, serial_rx_pin asynchronous, cpu_mask_flag on clk
// Function
// - word length 8 or 9 bits both ways
// - start bit low, stop bit high
// - idle frame is a whole frame of ones
// - ninth transmitted bit comes from tx_ninth_bit
// - both directions shift least significant bit first
// - enable sends idle; re-enable during a running frame drops holding buffer
// - status then data write clears transmit flags
// - busy write fills holding, idle write starts directly
// - tx_empty_flag on holding move, maskable interrupt
// - tx_done_flag after stop or break frame
// - break frames while set, then one mark bit
// - received ninth bit goes to rx_ninth_bit
// - rx_enable starts the start bit search
// - character moves to holding, sets rx_full_flag
// - software empties holding before next character ends
// - overrun keeps holding, sets flag, shift overwritten
// - idle frame acts as character plus interrupt
// - samples 8-10 must agree else noise flag
// - false start discarded, noise shown with next frame
// - missing stop or break sets framing flag
// - independent rates: clock over 16, prescaler, divider
// - enabled and quiet line held high
// - sixteen samples a bit, majority of 8-10
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
module sci_top (
   input wire logic clk,
   input wire logic nrst,
   input wire logic en,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic cpu_mask_flag,
   input wire logic serial_rx_pin,
   output logic serial_tx_pin,
   output logic serial_tx_oe,
   output logic irq_req
);
   typedef struct packed {
      logic wreq;                  // waitrequest
      logic [7:0] rdata;           // read data
      logic armed;                 // status seen, data access pending
      sci_pkg::ctrl_t ctl;         // software controls
      sci_pkg::baud_t baud;        // rate selection
      logic tx_empty;              // tx_empty_flag
      logic tx_done;               // tx_done_flag
      logic rx_full;               // rx_full_flag
      logic idle;                  // idle line flag
      logic ovr;                   // rx_overrun_flag
      logic noise;                 // rx_noise_flag
      logic fe;                    // rx_framing_flag
      logic rx9;                   // rx_ninth_bit
      logic [7:0] rhold;           // rx_holding_buffer
      logic [7:0] thold;           // tx_holding_buffer
      logic hold_full;             // holding buffer in use
      sci_pkg::tx_state_t tstate;  // transmitter state
      logic [10:0] tsh;            // transmit shift register
      logic [3:0] tbits;           // bits left in frame
      logic [3:0] tticks;          // ticks in current bit
      logic pend_idle;             // idle frame owed after this frame
      logic te_prev;               // tx_enable last cycle
      logic tdo;                   // serial_tx_pin
      logic tdo_oe;                // serial_tx_oe
      sci_pkg::rx_state_t rstate;  // receiver state
      logic [2:0] hist;            // last three line samples
      logic [3:0] rticks;          // sample index in bit
      logic [3:0] rbits;           // bit index, 0 is start
      logic [2:0] votes;           // samples 8..10
      logic fnoise;                // noise seen in this frame
      logic npend;                 // noise from a false start
      logic [8:0] rsh;             // receive shift register
      logic [7:0] idle_cnt;        // consecutive one-ticks
      logic idle_armed;            // a frame seen since last idle
      logic irq;                   // interrupt request
   } st_t;
   st_t q;
   st_t n;
   logic ttick;      // transmit oversample tick
   logic rtick;      // receive oversample tick
   logic rxd;        // resynchronised receive line
   logic acc;        // request taken this edge
   logic wr;         // write taken
   logic rd;         // read taken
   logic wr_data;    // write to data_port_reg taken
   logic rd_data;    // read of data_port_reg taken
   logic [7:0] wd;   // write byte
   logic [7:0] rmux; // read mux
   logic [3:0] flen; // frame length in bits
   logic [3:0] dlen; // data bits

   ////////////////////////////////////////////////////////////////////////////
   // rate generators: separate dividers so the two rates are independent
   sci_baud_tick #(.CW(11)) u_tx_rate (
      .clk(clk),
      .nrst(nrst),
      .en(en),
      .run(q.tstate != sci_pkg::TX_OFF),
      .pre_sel(q.baud.pre),
      .div_sel(q.baud.tdiv),
      .tick(ttick)
   );
   sci_baud_tick #(.CW(11)) u_rx_rate (
      .clk(clk),
      .nrst(nrst),
      .en(en),
      .run(q.ctl.re),
      .pre_sel(q.baud.pre),
      .div_sel(q.baud.rdiv),
      .tick(rtick)
   );
   sci_pin_sync u_rx_sync (
      .clk(clk),
      .nrst(nrst),
      .en(en),
      .pin(serial_rx_pin),
      .q_sync(rxd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus decode: a request is taken on the edge where waitrequest is low
   assign acc = (read | write) & ~q.wreq;
   assign wr = acc & write & byteenable[0];
   assign rd = acc & read;
   assign wr_data = wr && (address == sci_pkg::OFS_DATA);
   assign rd_data = rd && (address == sci_pkg::OFS_DATA);
   assign wd = writedata[7:0];
   assign flen = q.ctl.word9 ? sci_pkg::FRAME_BITS_9 : sci_pkg::FRAME_BITS_8;
   assign dlen = q.ctl.word9 ? sci_pkg::DATA_BITS_9 : sci_pkg::DATA_BITS_8;

   // frame image, sent from bit 0 upward: start, data lsb first, ninth, stop
   function automatic logic [10:0] frame_of(input logic [7:0] d, input logic w9, input logic t9);
      frame_of = {1'b1, (w9 ? t9 : 1'b1), d, 1'b0};
   endfunction

   // read mux; unmapped offsets read as zero
   always_comb begin
      unique case (address)
         sci_pkg::OFS_STATUS: rmux = {q.tx_empty, q.tx_done, q.rx_full, q.idle, q.ovr, q.noise, q.fe, 1'b0};
         sci_pkg::OFS_DATA: rmux = q.rhold;
         sci_pkg::OFS_CTRL1: rmux = {q.rx9, q.ctl.tx9, 1'b0, q.ctl.word9, 4'h0};
         sci_pkg::OFS_CTRL2: rmux = {q.ctl.ien_txe, q.ctl.ien_tc, q.ctl.ien_rx, q.ctl.ien_idle,
                                     q.ctl.te, q.ctl.re, 1'b0, q.ctl.brk};
         sci_pkg::OFS_BAUD: rmux = q.baud;
         default: rmux = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state of the whole block
   always_comb begin
      logic [3:0] s;
      logic [2:0] v;
      logic maj;
      logic unan;
      s = 4'h0;
      v = 3'h0;
      maj = 1'b0;
      unan = 1'b0;
      n = q;
      // one wait cycle, then a single accept cycle
      n.wreq = !((read | write) && q.wreq);
      if ((read | write) && q.wreq) begin
         n.rdata = rmux;
      end
      // register writes
      if (wr && address == sci_pkg::OFS_CTRL1) begin
         n.ctl.tx9 = wd[sci_pkg::C1_TX9];
         n.ctl.word9 = wd[sci_pkg::C1_WORD9];
      end
      if (wr && address == sci_pkg::OFS_CTRL2) begin
         {n.ctl.ien_txe, n.ctl.ien_tc, n.ctl.ien_rx, n.ctl.ien_idle, n.ctl.te, n.ctl.re} = wd[7:2];
         n.ctl.brk = wd[0];
      end
      if (wr && address == sci_pkg::OFS_BAUD) begin
         n.baud = wd;
      end
      // status-then-data clearing; hardware sets below win over these clears
      if (rd && address == sci_pkg::OFS_STATUS) begin
         n.armed = 1'b1;
      end
      if (wr_data || rd_data) begin
         n.armed = 1'b0;
      end
      if (wr_data && q.armed) begin
         n.tx_empty = 1'b0;
         n.tx_done = 1'b0;
      end
      if (rd_data && q.armed) begin
         {n.rx_full, n.idle, n.ovr, n.noise, n.fe} = 5'h00;
      end

      // ---- transmitter ----
      n.te_prev = q.ctl.te;
      if (wr_data) begin
         if (q.tstate == sci_pkg::TX_READY && q.ctl.te && !q.ctl.brk && !q.hold_full) begin
            n.tsh = frame_of(wd, q.ctl.word9, q.ctl.tx9);
            n.tstate = sci_pkg::TX_DATA;
            n.tbits = flen;
            n.tticks = 4'h0;
            n.tx_empty = 1'b1;
         end else begin
            n.thold = wd;
            n.hold_full = 1'b1;
         end
      end
      // rising tx_enable: idle frame now, or after the running frame
      if (q.ctl.te && !q.te_prev) begin
         if (q.tstate == sci_pkg::TX_OFF || q.tstate == sci_pkg::TX_READY) begin
            n.tstate = sci_pkg::TX_PREAMBLE;
            n.tsh = '1;
            n.tbits = flen;
            n.tticks = 4'h0;
         end else begin
            n.pend_idle = 1'b1;
            n.hold_full = 1'b0;
         end
      end else if (q.tstate == sci_pkg::TX_READY) begin
         // quiet line: pick up a break or a buffered word
         if (!q.ctl.te) begin
            n.tstate = sci_pkg::TX_OFF;
         end else if (q.ctl.brk) begin
            n.tstate = sci_pkg::TX_BREAK;
            n.tsh = '0;
            n.tbits = flen;
            n.tticks = 4'h0;
         end else if (q.hold_full && !wr_data) begin
            n.tstate = sci_pkg::TX_DATA;
            n.tsh = frame_of(q.thold, q.ctl.word9, q.ctl.tx9);
            n.tbits = flen;
            n.tticks = 4'h0;
            n.hold_full = 1'b0;
            n.tx_empty = 1'b1;
         end
      end else if (q.tstate != sci_pkg::TX_OFF && ttick) begin
         n.tticks = 4'(q.tticks + 4'h1);
         if (q.tticks == sci_pkg::TICK_LAST) begin
            // break frames shift in zeros so the pin stays low
            n.tsh = {(q.tstate != sci_pkg::TX_BREAK), q.tsh[10:1]};
            n.tbits = 4'(q.tbits - 4'h1);
            if (q.tbits == 4'h1) begin
               if (q.tstate == sci_pkg::TX_DATA || q.tstate == sci_pkg::TX_BREAK) begin
                  n.tx_done = 1'b1;
               end
               n.tticks = 4'h0;
               if (q.ctl.brk) begin
                  n.tstate = sci_pkg::TX_BREAK;
                  n.tsh = '0;
                  n.tbits = flen;
               end else if (q.tstate == sci_pkg::TX_BREAK) begin
                  n.tstate = sci_pkg::TX_MARK;
                  n.tsh = '1;
                  n.tbits = 4'h1;
               end else if (q.pend_idle) begin
                  n.tstate = sci_pkg::TX_PREAMBLE;
                  n.tsh = '1;
                  n.tbits = flen;
                  n.pend_idle = 1'b0;
               end else if (n.hold_full && q.ctl.te) begin
                  n.tstate = sci_pkg::TX_DATA;
                  n.tsh = frame_of(n.thold, q.ctl.word9, q.ctl.tx9);
                  n.tbits = flen;
                  n.hold_full = 1'b0;
                  n.tx_empty = 1'b1;
               end else begin
                  n.tstate = sci_pkg::TX_READY;
               end
            end
         end
      end
      // quiet or released line stands high
      n.tdo = (n.tstate == sci_pkg::TX_OFF || n.tstate == sci_pkg::TX_READY) ? 1'b1 : n.tsh[0];
      n.tdo_oe = n.ctl.te | n.ctl.re;

      // ---- receiver ----
      if (!q.ctl.re) begin
         n.rstate = sci_pkg::RX_OFF;
      end else if (q.rstate == sci_pkg::RX_OFF) begin
         n.rstate = sci_pkg::RX_HUNT;
         n.idle_cnt = 8'h00;
         n.idle_armed = 1'b0;
      end else if (rtick) begin
         n.hist = {q.hist[1:0], rxd};
         if (q.rstate == sci_pkg::RX_HUNT) begin
            if (!rxd) begin
               // falling edge: starts a frame, noise unless after three ones
               n.rstate = sci_pkg::RX_FRAME;
               n.rticks = 4'h1;
               n.rbits = 4'h0;
               n.fnoise = (q.hist != 3'h7);
               n.idle_cnt = 8'h00;
               n.idle_armed = 1'b1;
            end else begin
               n.idle_cnt = 8'(q.idle_cnt + 8'h01);
               if (q.idle_armed && n.idle_cnt == (q.ctl.word9 ? sci_pkg::IDLE_TICKS_9 : sci_pkg::IDLE_TICKS_8)) begin
                  n.idle_armed = 1'b0;
                  n.idle = 1'b1;
                  if (n.rx_full) begin
                     n.ovr = 1'b1;
                  end else begin
                     n.rx_full = 1'b1;
                  end
               end
            end
         end else begin
            s = 4'(q.rticks + 4'h1);
            n.rticks = s;
            if (q.rbits == 4'h0 && (s == sci_pkg::SMP_3 || s == sci_pkg::SMP_5 || s == sci_pkg::SMP_7) && rxd) begin
               n.fnoise = 1'b1;
            end
            if (s >= sci_pkg::SMP_8 && s <= sci_pkg::SMP_10) begin
               n.votes = {q.votes[1:0], rxd};
            end
            if (s == sci_pkg::SMP_10) begin
               v = {q.votes[1:0], rxd};
               maj = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
               unan = (v == 3'h0) || (v == 3'h7);
               n.rbits = 4'(q.rbits + 4'h1);
               if (q.rbits == 4'h0) begin
                  if (maj) begin
                     n.rstate = sci_pkg::RX_HUNT;
                     n.npend = 1'b1;
                  end else if (!unan) begin
                     n.fnoise = 1'b1;
                  end
               end else if (q.rbits <= dlen) begin
                  n.rsh = {maj, q.rsh[8:1]};
                  n.fnoise = q.fnoise | !unan;
               end else begin
                  n.rstate = sci_pkg::RX_HUNT;
                  if (n.rx_full) begin
                     n.ovr = 1'b1;
                  end else begin
                     n.rx_full = 1'b1;
                     n.rhold = q.ctl.word9 ? q.rsh[7:0] : q.rsh[8:1];
                     n.rx9 = q.ctl.word9 & q.rsh[8];
                     n.noise = q.fnoise | q.npend | !unan;
                     n.fe = !maj;
                     n.npend = 1'b0;
                  end
               end
            end
         end
      end

      // interrupt request, gated by the cpu mask
      n.irq = !cpu_mask_flag && ((q.ctl.ien_txe & q.tx_empty) | (q.ctl.ien_tc & q.tx_done) |
              (q.ctl.ien_rx & (q.rx_full | q.ovr)) | (q.ctl.ien_idle & q.idle));
   end

   // state register, frozen while en is low
   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= '0;
         q.wreq <= 1'b1;
         q.tx_empty <= 1'b1;
         q.tx_done <= 1'b1;
         q.tdo <= 1'b1;
         q.hist <= 3'h7;
      end else if (en) begin
         q <= n;
      end
   end
   assign readdata = {24'h000000, q.rdata};
   assign waitrequest = q.wreq;
   assign serial_tx_pin = q.tdo;
   assign serial_tx_oe = q.tdo_oe;
   assign irq_req = q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_wr_ready;
      en && wr_data && q.tstate == sci_pkg::TX_READY && q.ctl.te && !q.ctl.brk && !q.hold_full && q.te_prev;
   endsequence
   sequence s_tx_start;
      $past(q.tstate) == sci_pkg::TX_READY && q.tstate == sci_pkg::TX_DATA;
   endsequence
   AST_TX_START_LOW: assert property (s_tx_start |-> !q.tdo) else $error("start bit not low");
   AST_TX_STOP_HIGH: assert property (q.tstate == sci_pkg::TX_DATA && q.tbits == 4'h1 |-> q.tdo)
      else $error("stop bit not high");
   AST_TX_IDLE_HIGH: assert property (q.tstate == sci_pkg::TX_PREAMBLE |-> q.tdo) else $error("idle frame not high");
   AST_TX_BREAK_LOW: assert property (q.tstate == sci_pkg::TX_BREAK |-> !q.tdo) else $error("break not low");
   AST_TX_QUIET_HIGH: assert property ((q.tstate == sci_pkg::TX_READY || q.tstate == sci_pkg::TX_OFF) |-> q.tdo)
      else $error("quiet line not high");
   AST_TX_DIRECT: assert property (s_wr_ready |=> q.tstate == sci_pkg::TX_DATA && q.tx_empty ##1 !q.tdo)
      else $error("direct load failed");
   AST_TXE_CLEAR: assert property ($fell(q.tx_empty) |-> $past(wr_data && q.armed)) else $error("bad empty clear");
   AST_OVR_HOLD: assert property ($rose(q.ovr) |-> $stable(q.rhold)) else $error("holding lost on overrun");
   AST_NOISE_FULL: assert property ($rose(q.noise) |-> $rose(q.rx_full)) else $error("noise without full");
   AST_RX_IRQ: assert property (en && q.rx_full && q.ctl.ien_rx && !cpu_mask_flag |=> q.irq)
      else $error("receive interrupt missing");
endmodule

// ### dv/sci_line_model.sv
// far-side serial equipment: sends frames on our receive pin, captures ours
// assumes 8-bit words at 16 clocks a bit (fastest rate)
module sci_line_model (
   input wire logic clk,
   input wire logic tx,
   output logic rx
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] got; // last byte captured
   int n_got = 0; // frames captured
   initial rx = 1'b1; // line idles high
   // sample mid-bit on the falling clock, away from the launch edge
   always begin
      @(negedge tx);
      repeat (24) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
         got[i] = tx; // lsb first
         repeat (16) @(negedge clk);
      end
      n_got++;
   end
   // one frame: low start, data lsb first, high stop
   task automatic send(input logic [7:0] d);
      for (int i = 0; i < 10; i++) begin
         rx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1]; // framing
         repeat (16) @(posedge clk);
      end
   endtask
endmodule

// ### dv/async_serial_comm_interface_tb_top.sv
// bench: avalon accesses plus serial traffic through the line model
// assumes baud register left at zero, 16 clocks a bit, never rewritten while enabled
module async_serial_comm_interface_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
   logic [4:0] address = 5'h00;
   logic [31:0] writedata = 32'h00000000, readdata;
   logic waitrequest, tx, oe, irq, rx;
   logic [3:0] be = 4'hF; // byte enables, dropped once to test masking
   logic mask = 1'b0; // cpu interrupt mask
   logic [7:0] q; // last value read
   int bad_count = 0, n_checks = 0, cyc = 0, c0;
   always #12.5 clk = ~clk;
   sci_top dut_u (.clk(clk), .nrst(nrst), .en(1'b1), .address(address), .read(read), .write(write),
      .byteenable(be), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .cpu_mask_flag(mask), .serial_rx_pin(rx), .serial_tx_pin(tx), .serial_tx_oe(oe), .irq_req(irq));
   sci_line_model peer_u (.clk(clk), .tx(tx), .rx(rx));
   // one avalon cycle; held until the rising edge where waitrequest is low, data taken there
   task automatic acc(input logic [4:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      address <= a;
      read <= !w;
      write <= w;
      writedata <= {24'h000000, d};
      do @(posedge clk); while (waitrequest !== 1'b0);
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic chk(input logic [7:0] m, input logic [7:0] e);
      n_checks++;
      if ((q & m) !== e) begin
         $display("ERROR %0t got %h want %h", $time, q & m, e);
         bad_count++;
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // hang guard, far above the fewer than two thousand cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         $display("ERROR %0t timeout", $time);
         bad_count++;
         close_out();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      acc(sci_pkg::OFS_STATUS, 0, 8'h00);
      chk(8'hFF, 8'hC0); // reset flags
      q = {7'h00, oe};
      chk(8'h01, 8'h00); // pin released while both disabled
      acc(sci_pkg::OFS_CTRL2, 1, 8'h2C);
      acc(sci_pkg::OFS_STATUS, 0, 8'h00);
      acc(sci_pkg::OFS_DATA, 1, 8'hA5);
      c0 = cyc;
      acc(sci_pkg::OFS_STATUS, 0, 8'h00);
      chk(8'hC0, 8'h00); // flags cleared by sequence
      wait (peer_u.n_got == 1);
      q = {7'h00, (cyc - c0) > 250};
      chk(8'h01, 8'h01); // idle frame came first
      q = peer_u.got;
      chk(8'hFF, 8'hA5); // byte on the wire
      repeat (40) @(posedge clk);
      acc(sci_pkg::OFS_STATUS, 0, 8'h00);
      chk(8'hC0, 8'hC0); // frame done
      q = {7'h00, oe};
      chk(8'h01, 8'h01); // pin owned while enabled
      acc(sci_pkg::OFS_DATA, 1, 8'h96); // quiet line: direct load
      acc(sci_pkg::OFS_STATUS, 0, 8'h00);
      chk(8'hC0, 8'h80); // empty at once, done cleared
      wait (peer_u.n_got == 2);
      q = peer_u.got;
      chk(8'hFF, 8'h96); // direct byte on the wire
      $display("tx test done");
      repeat (40) @(posedge clk);
      acc(sci_pkg::OFS_CTRL2, 1, 8'h2D); // break on
      repeat (30) @(posedge clk);
      q = {7'h00, tx};
      chk(8'h01, 8'h00); // break holds line low
      acc(sci_pkg::OFS_CTRL2, 1, 8'h2C); // break off
      wait (peer_u.n_got == 3);
      q = peer_u.got;
      chk(8'hFF, 8'h00); // zeros in all eight data bits
      repeat (40) @(posedge clk);
      q = {7'h00, tx};
      chk(8'h01, 8'h01); // mark bit then quiet high
      $display("break test done");
      peer_u.send(8'h3C);
      peer_u.send(8'hC3);
      repeat (4) @(posedge clk);
      acc(sci_pkg::OFS_STATUS, 0, 8'h00);
      chk(8'h3F, 8'h28); // second byte overran
      q = {7'h00, irq};
      chk(8'h01, 8'h01); // receive interrupt raised
      mask <= 1'b1;
      repeat (2) @(posedge clk);
      q = {7'h00, irq};
      chk(8'h01, 8'h00); // held off by the cpu mask
      mask <= 1'b0;
      acc(sci_pkg::OFS_DATA, 0, 8'h00);
      chk(8'hFF, 8'h3C); // holding kept
      acc(sci_pkg::OFS_STATUS, 0, 8'h00);
      chk(8'h3F, 8'h00); // cleared by status then data read
      repeat (200) @(posedge clk);
      acc(sci_pkg::OFS_STATUS, 0, 8'h00);
      chk(8'h3F, 8'h30); // quiet line seen as idle
      acc(sci_pkg::OFS_DATA, 0, 8'h00);
      peer_u.send(8'h5A);
      repeat (4) @(posedge clk);
      acc(sci_pkg::OFS_STATUS, 0, 8'h00);
      chk(8'h3F, 8'h20); // clean byte, no error flags
      acc(sci_pkg::OFS_DATA, 0, 8'h00);
      chk(8'hFF, 8'h5A); // byte read back intact, 0x5A reads the same either bit order
      $display("rx test done");
      acc(5'h14, 0, 8'h00);
      chk(8'hFF, 8'h00);
      be <= 4'h0;
      acc(sci_pkg::OFS_CTRL1, 1, 8'h50);
      be <= 4'hF;
      acc(sci_pkg::OFS_CTRL1, 0, 8'h00);
      chk(8'hFF, 8'h00); // word length kept on a masked write
      $display("map test done");
      close_out();
   end
endmodule
